// >>> hdl/coi_channel_override.v
// Output arbitration, diagnostic pulses and integrity readback for eight channels
//
// Behaviour
// - OFF pulse forces channel off 100-150 us
// - ON pulse forces channel on 80-120 us
// - After pulse, normal control source resumes
// - Frame 9 pulse requests latched, cleared when done
// - Requests ignored while channel pulse latched
// - Both requested: pulse opposite current state
// - H-bridge channels ignore pulse requests
// - Kill pins, logic supply faults stop ch1-6
// - Self test three-states; self check mixed
// - Battery or pump undervoltage stops all
// - Enable clear three-states; protective bit offs
// - Channel six pin low stops channel 6
// - Reset pin, overcurrent, watchdog latch off
// - Short and open faults only latched
// - Bridged ch7-8 follow ch1-6 responses
// - Integrity request answered in next frame
// - Integrity frame header, fields, even parity
// - P-channel gate code 100/010/000
// - N-channel gate code 001/010/000
// - Command bit from source select logic
// - Level bit reports output comparator
`include "coi_regs.vh"

module coi_channel_override (
	input  wire       clk,
	input  wire       nrst,
	input  wire       spi_sck,
	input  wire       spi_csn_n,
	input  wire       spi_mosi,
	output reg        spi_miso_ff,
	input  wire       kill_pin_high,
	input  wire       kill_pin_low_n,
	input  wire       logic_supply_uv,
	input  wire       logic_supply_ov,
	input  wire       logic_self_test_busy,
	input  wire       logic_self_test_fail,
	input  wire       comparator_self_check_busy,
	input  wire       comparator_self_check_fail,
	input  wire       battery_supply_uv,
	input  wire       charge_pump_uv,
	input  wire       channel_six_enable_pin,
	input  wire       reset_pin_low_n,
	input  wire       comm_check_watchdog_fail,
	input  wire [7:0] direct_control_pin_n,
	input  wire [7:0] output_level_cmp,
	input  wire [7:0] overcurrent_fault,
	input  wire [7:0] short_to_ground,
	input  wire [7:0] short_to_battery,
	input  wire [7:0] open_load,
	input  wire [7:0] serial_on_bit,
	input  wire [7:0] control_source_select,
	input  wire [7:0] output_enable_bit,
	input  wire [7:0] protective_off_bit,
	input  wire [7:0] p_channel_cfg,
	input  wire       hbridge_mode,
	input  wire       reengage_req,
	output reg  [7:0] gate_on_ff,
	output reg  [7:0] gate_tri_ff,
	output reg  [7:0] manual_off_ff,
	output reg  [7:0] manual_tri_ff,
	output wire [7:0] on_pulse_busy,
	output wire [7:0] off_pulse_busy,
	output reg  [7:0] short_to_ground_ff,
	output reg  [7:0] short_to_battery_ff,
	output reg  [7:0] open_load_ff
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	wire [`COI_SYNC_W-1:0] async_in;
	reg  [`COI_SYNC_W-1:0] meta_ff;
	reg  [`COI_SYNC_W-1:0] sync_ff;

	assign async_in = {open_load, short_to_battery, short_to_ground, overcurrent_fault,
		output_level_cmp, direct_control_pin_n, spi_sck, spi_mosi,
		comm_check_watchdog_fail, reset_pin_low_n, channel_six_enable_pin,
		charge_pump_uv, battery_supply_uv, comparator_self_check_fail,
		comparator_self_check_busy, logic_self_test_fail, logic_self_test_busy,
		logic_supply_ov, logic_supply_uv, kill_pin_low_n, kill_pin_high, spi_csn_n};

	// Reset levels match the idle pins, so no false edge or disable follows reset
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= `COI_SYNC_RST;
			sync_ff <= `COI_SYNC_RST;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	wire       s_csn    = sync_ff[`COI_S_CSN];
	wire       s_sck    = sync_ff[`COI_S_SCK];
	wire       s_mosi   = sync_ff[`COI_S_MOSI];
	wire [7:0] s_dcp_n  = sync_ff[`COI_S_DCP_LSB +: 8];
	wire [7:0] s_cmp    = sync_ff[`COI_S_CMP_LSB +: 8];
	wire [7:0] s_oc     = sync_ff[`COI_S_OC_LSB +: 8];
	wire [7:0] s_stg    = sync_ff[`COI_S_STG_LSB +: 8];
	wire [7:0] s_stb    = sync_ff[`COI_S_STB_LSB +: 8];
	wire [7:0] s_ol     = sync_ff[`COI_S_OL_LSB +: 8];

	// ----------------------------------------------------------------
	// Channel groups and disable sources
	// ----------------------------------------------------------------
	// Safety group: channels 1-6, plus 7-8 once bridged
	wire [7:0] grp      = {hbridge_mode, hbridge_mode, 6'h3F};
	wire [7:0] all_ch   = 8'hFF;
	wire [7:0] ch_six   = 8'h20;

	wire auto_grp_off = sync_ff[`COI_S_KILL_H] | ~sync_ff[`COI_S_KILL_N]
		| sync_ff[`COI_S_LS_UV];
	wire auto_all_off = sync_ff[`COI_S_BS_UV] | sync_ff[`COI_S_CP_UV];
	wire lst_busy     = sync_ff[`COI_S_LST_BUSY];
	wire csc_busy     = sync_ff[`COI_S_CSC_BUSY];
	wire test_fail    = sync_ff[`COI_S_LST_FAIL] | sync_ff[`COI_S_CSC_FAIL];
	wire ls_ov        = sync_ff[`COI_S_LS_OV];
	wire ccw_fail     = sync_ff[`COI_S_CCW_FAIL];
	wire rst_pin      = ~sync_ff[`COI_S_RST_N];
	wire en6_low      = ~sync_ff[`COI_S_EN6];

	// Automatic sources act only while present
	wire [7:0] auto_off = ({8{auto_grp_off}} & grp)
		| ({8{auto_all_off}} & all_ch)
		| ({8{csc_busy}} & grp)
		| ({8{en6_low}} & ch_six);
	wire [7:0] auto_tri = ({8{lst_busy}} & all_ch)
		| ({8{csc_busy}} & ~grp);

	// Latching sources hold until re-engagement with the cause gone
	wire [7:0] set_man_off = ({8{ls_ov | test_fail | ccw_fail}} & grp)
		| ({8{rst_pin}} & all_ch)
		| s_oc
		| protective_off_bit;
	wire [7:0] set_man_tri = ({8{test_fail}} & ~grp)
		| ~output_enable_bit;

	// ----------------------------------------------------------------
	// Manual re-engagement latches
	// ----------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			manual_off_ff <= 8'h00;
			manual_tri_ff <= 8'h00;
		end else begin
			// A cause still present re-sets in the clear cycle, so set wins
			manual_off_ff <= (reengage_req ? 8'h00 : manual_off_ff) | set_man_off;
			manual_tri_ff <= (reengage_req ? 8'h00 : manual_tri_ff) | set_man_tri;
		end
	end

	// ----------------------------------------------------------------
	// Fault records
	// ----------------------------------------------------------------
	// Faults below never touch the outputs, they are only recorded
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			short_to_ground_ff  <= 8'h00;
			short_to_battery_ff <= 8'h00;
			open_load_ff        <= 8'h00;
		end else begin
			short_to_ground_ff  <= (reengage_req ? 8'h00 : short_to_ground_ff) | s_stg;
			short_to_battery_ff <= (reengage_req ? 8'h00 : short_to_battery_ff) | s_stb;
			open_load_ff        <= (reengage_req ? 8'h00 : open_load_ff) | s_ol;
		end
	end

	// ----------------------------------------------------------------
	// Serial slave, sampled by the system clock
	// ----------------------------------------------------------------
	reg                       sck_d_ff;
	reg                       csn_d_ff;
	reg  [`COI_FRAME_BITS-1:0] rx_ff;
	reg  [`COI_FRAME_BITS-1:0] tx_ff;
	reg  [`COI_FRAME_BITS-1:0] pend_ff;
	reg  [`COI_BIT_CNT_W-1:0]  bit_cnt_ff;
	reg  [7:0]                 req_on_ff;
	reg  [7:0]                 req_off_ff;
	wire [`COI_FRAME_BITS-1:0] resp_low;
	wire [`COI_FRAME_BITS-1:0] resp_high;

	wire sck_rise  = s_sck & ~sck_d_ff;
	wire sck_fall  = ~s_sck & sck_d_ff;
	wire csn_fall  = ~s_csn & csn_d_ff;
	wire csn_rise  = s_csn & ~csn_d_ff;
	wire frame_ok  = (bit_cnt_ff == 6'h20);
	wire is_pulse  = rx_ff[`COI_CMD_CODE_MSB:`COI_CMD_CODE_LSB] == `COI_CMD_PULSE_CODE;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sck_d_ff    <= 1'b0;
			csn_d_ff    <= 1'b1;
			rx_ff       <= 32'h0000_0000;
			tx_ff       <= 32'h0000_0000;
			pend_ff     <= 32'h0000_0000;
			bit_cnt_ff  <= 6'h00;
			spi_miso_ff <= 1'b0;
			req_on_ff   <= 8'h00;
			req_off_ff  <= 8'h00;
		end else begin
			sck_d_ff   <= s_sck;
			csn_d_ff   <= s_csn;
			req_on_ff  <= 8'h00;
			req_off_ff <= 8'h00;
			if (csn_fall) begin
				// Answer to the previous frame goes out now
				tx_ff       <= pend_ff;
				spi_miso_ff <= pend_ff[31];
				bit_cnt_ff  <= 6'h00;
			end else if (!s_csn && sck_rise) begin
				rx_ff      <= {rx_ff[30:0], s_mosi};
				// Saturate, so an overlong frame never wraps back to a valid count
				bit_cnt_ff <= (bit_cnt_ff == 6'h3F) ? bit_cnt_ff : bit_cnt_ff + 6'h01;
			end else if (!s_csn && sck_fall) begin
				tx_ff       <= {tx_ff[30:0], 1'b0};
				spi_miso_ff <= tx_ff[30];
			end else if (csn_rise) begin
				// Any other frame leaves no answer for the next one
				pend_ff <= 32'h0000_0000;
				if (frame_ok && rx_ff == `COI_REQ_LOW_FRAME) begin
					pend_ff <= resp_low;
				end else if (frame_ok && rx_ff == `COI_REQ_HIGH_FRAME) begin
					pend_ff <= resp_high;
				end else if (frame_ok && is_pulse) begin
					req_on_ff  <= rx_ff[`COI_CMD_ON_MSB:`COI_CMD_ON_LSB];
					req_off_ff <= rx_ff[`COI_CMD_OFF_MSB:`COI_CMD_OFF_LSB];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Per channel control
	// ----------------------------------------------------------------
	wire [7:0]  cmd_on;
	wire [7:0]  nxt_gate_on;
	wire [7:0]  nxt_gate_tri;
	wire [23:0] gcs;

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_ch
			// Only the bridged pair sees the bridge flag
			coi_pulse_chan u_pulse (
				.clk         (clk),
				.nrst        (nrst),
				.req_on      (req_on_ff[i]),
				.req_off     (req_off_ff[i]),
				.hbridge     (hbridge_mode & (i >= 6)),
				.out_is_on   (gate_on_ff[i]),
				.on_busy_ff  (on_pulse_busy[i]),
				.off_busy_ff (off_pulse_busy[i])
			);

			// Pin is active low, select high picks the serial bit
			assign cmd_on[i] = control_source_select[i] ? serial_on_bit[i]
				: ~s_dcp_n[i];

			// Three-state beats active off, which beats any pulse
			assign nxt_gate_tri[i] = auto_tri[i] | manual_tri_ff[i];
			assign nxt_gate_on[i]  = ~nxt_gate_tri[i] & ~auto_off[i] & ~manual_off_ff[i]
				& ~off_pulse_busy[i] & (on_pulse_busy[i] | cmd_on[i]);

			assign gcs[3*i +: 3] = gate_tri_ff[i] ? `COI_GCS_TRI
				: p_channel_cfg[i] ? (gate_on_ff[i] ? `COI_GCS_P_ON : `COI_GCS_P_OFF)
				: (gate_on_ff[i] ? `COI_GCS_N_ON : `COI_GCS_N_OFF);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Gate output registers
	// ----------------------------------------------------------------
	// Reset holds every channel three-state until the first clock edge after reset is released, while the synchronisers still hold their reset levels
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gate_on_ff  <= 8'h00;
			gate_tri_ff <= 8'hFF;
		end else begin
			gate_on_ff  <= nxt_gate_on;
			gate_tri_ff <= nxt_gate_tri;
		end
	end

	// ----------------------------------------------------------------
	// Integrity readback frames
	// ----------------------------------------------------------------
	// Gate codes come from the registered gate state, so they show what is driven
	wire [30:0] body_low  = {`COI_RESP_LOW_HDR, `COI_RESP_MARK, `COI_RESP_PATTERN,
		s_cmp[3:0],
		cmd_on[3:0],
		gcs[11:0]};
	wire [30:0] body_high = {`COI_RESP_HIGH_HDR, `COI_RESP_MARK, `COI_RESP_PATTERN,
		s_cmp[7:4],
		cmd_on[7:4],
		gcs[23:12]};

	assign resp_low  = {body_low, ^body_low};
	assign resp_high = {body_high, ^body_high};

endmodule // coi_channel_override

// >>> hdl/coi_pulse_chan.v
// One channel of the silent diagnostic pulse generator
`include "coi_regs.vh"

module coi_pulse_chan (
	input  wire clk,
	input  wire nrst,
	input  wire req_on,
	input  wire req_off,
	input  wire hbridge,
	input  wire out_is_on,
	output reg  on_busy_ff,
	output reg  off_busy_ff
);

	localparam [`COI_PULSE_CNT_W-1:0] ON_CYC  = `COI_ON_PULSE_CYC;
	localparam [`COI_PULSE_CNT_W-1:0] OFF_CYC = `COI_OFF_PULSE_CYC;
	localparam [`COI_PULSE_CNT_W-1:0] ONE     = 12'h001;

	reg  [`COI_PULSE_CNT_W-1:0] cnt_ff;
	reg  [`COI_PULSE_CNT_W-1:0] nxt_cnt;
	reg                         nxt_on_busy;
	reg                         nxt_off_busy;
	reg                         take_on;
	wire                        busy;

	assign busy = on_busy_ff | off_busy_ff;

	always @* begin
		nxt_cnt      = cnt_ff;
		nxt_on_busy  = on_busy_ff;
		nxt_off_busy = off_busy_ff;
		take_on      = req_on & (~req_off | ~out_is_on);
		// Requests are dropped while busy or in bridge mode
		if (!busy && !hbridge && (req_on || req_off)) begin
			nxt_on_busy  = take_on;
			nxt_off_busy = ~take_on;
			nxt_cnt      = take_on ? ON_CYC : OFF_CYC;
		end else if (busy) begin
			if (cnt_ff == ONE) begin
				nxt_on_busy  = 1'b0;
				nxt_off_busy = 1'b0;
			end
			nxt_cnt = cnt_ff - ONE;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff      <= 12'h000;
			on_busy_ff  <= 1'b0;
			off_busy_ff <= 1'b0;
		end else begin
			cnt_ff      <= nxt_cnt;
			on_busy_ff  <= nxt_on_busy;
			off_busy_ff <= nxt_off_busy;
		end
	end

endmodule // coi_pulse_chan

// >>> hdl/coi_regs.vh
// Constants of the channel override and integrity block
`ifndef COI_REGS_VH
`define COI_REGS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define COI_CLK_MHZ          25
`define COI_ON_PULSE_US      100
`define COI_OFF_PULSE_US     125
// Pulse lengths in system clocks, sized to the pulse counter
`define COI_ON_PULSE_CYC     12'h9C4
`define COI_OFF_PULSE_CYC    12'hC35
`define COI_PULSE_CNT_W      12

// ----------------------------------------------------------------
// Serial frames
// ----------------------------------------------------------------
`define COI_FRAME_BITS       32
`define COI_BIT_CNT_W        6
`define COI_REQ_LOW_FRAME    32'hBAAA_AAAA
`define COI_REQ_HIGH_FRAME   32'hCAAA_AAAB
`define COI_CMD_CODE_MSB     31
`define COI_CMD_CODE_LSB     28
`define COI_CMD_PULSE_CODE   4'h9
`define COI_CMD_ON_MSB       15
`define COI_CMD_ON_LSB       8
`define COI_CMD_OFF_MSB      7
`define COI_CMD_OFF_LSB      0
`define COI_RESP_LOW_HDR     4'hB
`define COI_RESP_HIGH_HDR    4'hC
`define COI_RESP_MARK        1'h1
`define COI_RESP_PATTERN     6'h15

// ----------------------------------------------------------------
// Gate current source codes
// ----------------------------------------------------------------
`define COI_GCS_TRI          3'h0
`define COI_GCS_P_ON         3'h4
`define COI_GCS_P_OFF        3'h2
`define COI_GCS_N_ON         3'h1
`define COI_GCS_N_OFF        3'h2

// ----------------------------------------------------------------
// Synchroniser vector (bit positions and reset levels)
// ----------------------------------------------------------------
`define COI_SYNC_W           64
`define COI_SYNC_RST         64'h0000_0000_00FF_1805
`define COI_S_CSN            0
`define COI_S_KILL_H         1
`define COI_S_KILL_N         2
`define COI_S_LS_UV          3
`define COI_S_LS_OV          4
`define COI_S_LST_BUSY       5
`define COI_S_LST_FAIL       6
`define COI_S_CSC_BUSY       7
`define COI_S_CSC_FAIL       8
`define COI_S_BS_UV          9
`define COI_S_CP_UV          10
`define COI_S_EN6            11
`define COI_S_RST_N          12
`define COI_S_CCW_FAIL       13
`define COI_S_MOSI           14
`define COI_S_SCK            15
`define COI_S_DCP_LSB        16
`define COI_S_CMP_LSB        24
`define COI_S_OC_LSB         32
`define COI_S_STG_LSB        40
`define COI_S_STB_LSB        48
`define COI_S_OL_LSB         56

`endif

// >>> test/coi_channel_override_asserts.sv
// Port checker for the channel override block
module coi_chk (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       kill_pin_high,
	input wire logic       battery_supply_uv,
	input wire logic       channel_six_enable_pin,
	input wire logic       logic_self_test_busy,
	input wire logic       hbridge_mode,
	input wire logic [7:0] output_enable_bit,
	input wire logic [7:0] protective_off_bit,
	input wire logic [7:0] short_to_ground,
	input wire logic [7:0] gate_on_ff,
	input wire logic [7:0] gate_tri_ff,
	input wire logic [7:0] on_pulse_busy,
	input wire logic [7:0] off_pulse_busy,
	input wire logic [7:0] short_to_ground_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [11:0] cnt_on_ff;
	logic [11:0] cnt_off_ff;

	// ----------------------------------------------------------------
	// Pulse length counters
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_on_ff <= 12'h000;
			cnt_off_ff <= 12'h000;
		end else begin
			cnt_on_ff <= on_pulse_busy[0] ? cnt_on_ff + 12'h001 : 12'h000;
			cnt_off_ff <= off_pulse_busy[1] ? cnt_off_ff + 12'h001 : 12'h000;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_kill_held;
		kill_pin_high[*5];
	endsequence
	sequence s_on_end;
		$fell(on_pulse_busy[0]);
	endsequence
	sequence s_off_end;
		$fell(off_pulse_busy[1]);
	endsequence

	a_tri_excl: assert property ((gate_tri_ff & gate_on_ff) == 8'h00)
		else $error("gate on while three-state");
	a_kill_off: assert property (s_kill_held |-> gate_on_ff[5:0] == 6'h00)
		else $error("kill did not stop low channels");
	a_bat_uv_off: assert property (battery_supply_uv[*5] |-> gate_on_ff == 8'h00)
		else $error("undervoltage did not stop all");
	a_en6_off: assert property (!channel_six_enable_pin[*5] |-> !gate_on_ff[5])
		else $error("channel six still on");
	a_test_tri: assert property (logic_self_test_busy[*5] |-> gate_tri_ff == 8'hFF)
		else $error("self test not three-state");
	a_outen_tri: assert property (!output_enable_bit[3][*4] |-> gate_tri_ff[3])
		else $error("disabled channel not three-state");
	a_prot_off: assert property (protective_off_bit[0][*4] |-> !gate_on_ff[0])
		else $error("protective off ignored");
	a_s2g_rec: assert property (short_to_ground[0][*5] |-> short_to_ground_ff[0])
		else $error("short not recorded");
	a_on_len: assert property (s_on_end |-> cnt_on_ff >= 12'h7D0 && cnt_on_ff <= 12'hBB8)
		else $error("on pulse length out of range");
	a_off_len: assert property (s_off_end |-> cnt_off_ff >= 12'h9C4 && cnt_off_ff <= 12'hEA6)
		else $error("off pulse length out of range");
	a_bridge_nop: assert property ($rose(on_pulse_busy[7]) |-> !$past(hbridge_mode))
		else $error("pulse on bridged channel");
endmodule // coi_chk

// >>> test/coi_channel_override_tb_top.sv
// Self-checking bench for the channel override block
module coi_channel_override_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, spi_sck, spi_csn_n, spi_mosi, spi_miso_ff, hbridge_mode, reengage_req;
	logic kill_pin_high, kill_pin_low_n, logic_supply_uv, logic_supply_ov, charge_pump_uv;
	logic logic_self_test_busy, logic_self_test_fail, comparator_self_check_busy;
	logic comparator_self_check_fail, battery_supply_uv, comm_check_watchdog_fail;
	logic channel_six_enable_pin, reset_pin_low_n;
	logic [7:0] direct_control_pin_n, output_level_cmp, overcurrent_fault, short_to_ground;
	logic [7:0] short_to_battery, open_load, serial_on_bit, control_source_select;
	logic [7:0] output_enable_bit, protective_off_bit, p_channel_cfg, gate_on_ff, gate_tri_ff;
	logic [7:0] manual_off_ff, manual_tri_ff, on_pulse_busy, off_pulse_busy, cmd_exp;
	logic [7:0] short_to_ground_ff, short_to_battery_ff, open_load_ff;
	logic [31:0] rx;
	int n_errors = 0;
	int checks = 0;
	// Expected gate_on per disable source while it is present, and manual flags
	logic [7:0] d_mask [16] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h00, 8'h00, 8'hDF, 8'h00,
		8'hC0, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [15:0] d_man = 16'hA788;

	assign cmd_exp = (control_source_select & serial_on_bit)
		| (~control_source_select & ~direct_control_pin_n);

	coi_channel_override dut (.*);
	coi_spi_host host (.sck(spi_sck), .csn_n(spi_csn_n), .mosi(spi_mosi), .miso(spi_miso_ff));

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t frame %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic reengage;
		@(posedge clk);
		reengage_req <= 1'b1;
		@(posedge clk);
		reengage_req <= 1'b0;
		cyc(8);
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		while (((on_pulse_busy | off_pulse_busy) !== 8'h00) && (k <= 4000)) begin
			k++;
			@(posedge clk);
		end
		if (k > 4000) begin
			n_errors++;
			$display("MISMATCH t=%0t pulse never ended", $time);
		end
	endtask
	function automatic logic [2:0] gcode(input int i);
		if (!output_enable_bit[i])
			return 3'h0;
		if (p_channel_cfg[i])
			return cmd_exp[i] ? 3'h4 : 3'h2;
		return cmd_exp[i] ? 3'h1 : 3'h2;
	endfunction
	function automatic logic [31:0] exp_int(input int o, input logic [3:0] hdr);
		logic [31:0] r;
		r = {hdr, 1'b1, 6'h15, output_level_cmp[o +: 4], cmd_exp[o +: 4],
			gcode(o + 3), gcode(o + 2), gcode(o + 1), gcode(o), 1'b0};
		r[0] = ^r[31:1];
		return r;
	endfunction
	task automatic drive_src(input int i, input logic v);
		@(posedge clk);
		case (i)
		0: kill_pin_high <= v;
		1: kill_pin_low_n <= ~v;
		2: logic_supply_uv <= v;
		3: logic_supply_ov <= v;
		4: battery_supply_uv <= v;
		5: charge_pump_uv <= v;
		6: channel_six_enable_pin <= ~v;
		7: reset_pin_low_n <= ~v;
		8: comm_check_watchdog_fail <= v;
		9: overcurrent_fault <= {8{v}};
		10: protective_off_bit <= {8{v}};
		11: begin
			short_to_ground <= {8{v}};
			short_to_battery <= {8{v}};
			open_load <= {8{v}};
		end
		12: logic_self_test_busy <= v;
		13: logic_self_test_fail <= v;
		14: comparator_self_check_busy <= v;
		default: comparator_self_check_fail <= v;
		endcase
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_integrity;
		@(posedge clk);
		p_channel_cfg <= 8'h35;
		control_source_select <= 8'h0F;
		serial_on_bit <= 8'h05;
		direct_control_pin_n <= 8'hAF;
		output_enable_bit <= 8'hF7;
		output_level_cmp <= 8'h3C;
		cyc(8);
		host.xfer(32'hBAAA_AAAA, rx);
		host.xfer(32'hCAAA_AAAB, rx);
		chk32(rx, exp_int(0, 4'hB));
		host.xfer(32'h0000_0000, rx);
		chk32(rx, exp_int(4, 4'hC));
		chk8(manual_tri_ff, 8'h08);
		chk8(gate_tri_ff, 8'h08);
		@(posedge clk);
		output_enable_bit <= 8'hFF;
		reengage();
	endtask
	task automatic test_pulses;
		@(posedge clk);
		control_source_select <= 8'hFF;
		serial_on_bit <= 8'h02;
		cyc(8);
		host.xfer(32'h9000_8303, rx);
		chk32(rx, 32'h0000_0000);
		cyc(8);
		chk8(on_pulse_busy, 8'h81);
		chk8(off_pulse_busy, 8'h02);
		chk8(gate_on_ff, 8'h81);
		host.xfer(32'h9000_0001, rx);
		cyc(8);
		chk8(off_pulse_busy, 8'h02);
		wait_idle();
		cyc(4);
		chk8(gate_on_ff, 8'h02);
		@(posedge clk);
		hbridge_mode <= 1'b1;
		host.xfer(32'h9000_C0C0, rx);
		cyc(8);
		chk8(on_pulse_busy | off_pulse_busy, 8'h00);
		@(posedge clk);
		hbridge_mode <= 1'b0;
	endtask
	task automatic test_disables;
		int i;
		@(posedge clk);
		serial_on_bit <= 8'hFF;
		for (i = 0; i < 16; i++) begin
			drive_src(i, 1'b1);
			cyc(8);
			chk8(gate_on_ff, d_mask[i]);
			drive_src(i, 1'b0);
			cyc(8);
			chk8(gate_on_ff, d_man[i] ? d_mask[i] : 8'hFF);
			chk8(manual_off_ff | manual_tri_ff, d_man[i] ? ~d_mask[i] : 8'h00);
			if (i == 11)
				chk8(short_to_ground_ff & short_to_battery_ff & open_load_ff, 8'hFF);
			reengage();
			chk8(gate_on_ff, 8'hFF);
			chk8(manual_off_ff | manual_tri_ff | short_to_ground_ff, 8'h00);
			chk8(short_to_battery_ff | open_load_ff, 8'h00);
		end
		@(posedge clk);
		hbridge_mode <= 1'b1;
		drive_src(0, 1'b1);
		cyc(8);
		chk8(gate_on_ff, 8'h00);
		drive_src(0, 1'b0);
		@(posedge clk);
		hbridge_mode <= 1'b0;
		cyc(8);
	endtask

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{hbridge_mode, reengage_req, kill_pin_high, logic_supply_uv, logic_supply_ov} = '0;
		{charge_pump_uv, logic_self_test_busy, logic_self_test_fail, battery_supply_uv} = '0;
		{comparator_self_check_busy, comparator_self_check_fail, comm_check_watchdog_fail} = '0;
		{output_level_cmp, overcurrent_fault, short_to_ground, short_to_battery} = '0;
		{open_load, serial_on_bit, control_source_select, protective_off_bit} = '0;
		{kill_pin_low_n, channel_six_enable_pin, reset_pin_low_n} = 3'h7;
		p_channel_cfg = 8'h00;
		direct_control_pin_n = 8'hFF;
		output_enable_bit = 8'hFF;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		cyc(4);
		reengage();
		test_integrity();
		test_pulses();
		test_disables();
		give_verdict();
	end
endmodule // coi_channel_override_tb_top

bind coi_channel_override coi_chk chk (.*);

// >>> test/coi_spi_host.sv
// Serial host model that sends whole frames and collects the replies
module coi_spi_host (
	output logic      sck,
	output logic      csn_n,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sck = 1'b0;
		csn_n = 1'b1;
		mosi = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frame transfer
	// ----------------------------------------------------------------
	// Clock idles low between frames; reply bits are taken late in the high phase
	// because the reply bit moves several system clocks after each falling edge
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		int i;
		#7 csn_n = 1'b0;
		#200;
		for (i = 31; i >= 0; i--) begin
			mosi = tx[i];
			#160 sck = 1'b1;
			#150 rx[i] = miso;
			#10 sck = 1'b0;
		end
		#160 csn_n = 1'b1;
		mosi = ~mosi;
		#240;
	endtask
endmodule // coi_spi_host
